// ==== hdl/dsf_cmp.sv ====
// dsf_cmp: registered below-threshold comparator for one analog level
// assumes level and threshold are unsigned and synchronous to clk
`timescale 1ns/1ns
module dsf_cmp
   import dsf_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [DSF_LVL_W-1:0] level,
   input wire logic [DSF_LVL_W-1:0] threshold,
   output logic below
);
   typedef struct packed {logic below;} dsf_cmp_st_t;
   dsf_cmp_st_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      s_d.below = level < threshold;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '{below: DSF_FLAG_RST};
      end else begin
         s_q <= s_d;
      end
   end

   assign below = s_q.below;
endmodule // dsf_cmp

// ==== hdl/dsf_pkg.sv ====
// dsf_pkg: constants and types shared by the drive status flag block
// assumes a 125 MHz clock and unsigned sampled levels from the converters
package dsf_pkg;

   // ==========================================================
   // widths
   localparam int DSF_LVL_W = 12;
   localparam int DSF_SEL_W = 6;
   localparam int DSF_NOUT = 3;

   // ==========================================================
   // output function codes
   localparam logic [DSF_SEL_W-1:0] DSF_FN_POS_DONE = 6'h17;
   localparam logic [DSF_SEL_W-1:0] DSF_FN_ANA_LOSS = 6'h1d;
   localparam logic [DSF_SEL_W-1:0] DSF_FN_STAGE2 = 6'h1f;

   // ==========================================================
   // current input: 4 mA as a level (20 mA is full scale)
   localparam logic [DSF_LVL_W-1:0] DSF_I_4MA_LVL = 12'h333;

   // ==========================================================
   // values after reset
   localparam logic DSF_FLAG_RST = 1'b0;
   localparam logic DSF_RUN_RST = 1'b0;

   typedef enum logic {DSF_STOPPED, DSF_RUNNING} dsf_run_t;

endpackage

// ==== hdl/dsf_route.sv ====
// dsf_route: maps a function code to one output terminal
// assumes flags are registered; output is registered again
`timescale 1ns/1ns
module dsf_route
   import dsf_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [DSF_SEL_W-1:0] sel,
   input wire logic pos_flag,
   input wire logic loss_flag,
   input wire logic stage_flag,
   output logic term
);
   typedef struct packed {logic term;} dsf_route_st_t;
   dsf_route_st_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      unique case (sel)
         DSF_FN_POS_DONE: s_d.term = pos_flag;
         DSF_FN_ANA_LOSS: s_d.term = loss_flag;
         DSF_FN_STAGE2: s_d.term = stage_flag;
         default: s_d.term = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '{term: DSF_FLAG_RST};
      end else begin
         s_q <= s_d;
      end
   end

   assign term = s_q.term;
endmodule // dsf_route

// ==== hdl/dsf_top.sv ====
// dsf_top: drive status flags and their routing to output terminals
// assumes all inputs synchronous to clk; levels are unsigned, same scale
`timescale 1ns/1ns
module dsf_top
   import dsf_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic positioning_finished,
   input wire logic use_current_input,
   input wire logic [DSF_LVL_W-1:0] v_input_level,
   input wire logic [DSF_LVL_W-1:0] i_input_level,
   input wire logic [DSF_LVL_W-1:0] start_frequency_setting,
   input wire logic loss_stop_enable,
   input wire logic forward_run_command,
   input wire logic [DSF_LVL_W-1:0] process_value,
   input wire logic [DSF_LVL_W-1:0] pv_low_limit,
   input wire logic [DSF_LVL_W-1:0] pv_high_limit,
   input wire logic [DSF_SEL_W-1:0] oc1_function,
   input wire logic [DSF_SEL_W-1:0] oc2_function,
   input wire logic [DSF_SEL_W-1:0] relay_function,
   output logic positioning_done_flag,
   output logic analog_loss_flag,
   output logic second_stage_request,
   output logic loss_decel_request,
   output logic [DSF_NOUT-1:0] output_terminals
);
   // ==========================================================
   // state
   typedef struct packed {
      logic pos_done;
      logic loss;
      logic stage2;
      logic decel;
      dsf_run_t run;
   } dsf_st_t;

   dsf_st_t s_q, s_d;
   logic v_below, i_below, pv_below_low;
   logic pv_above_high;
   logic [DSF_SEL_W-1:0] sel [DSF_NOUT];

   assign sel[0] = oc1_function;
   assign sel[1] = oc2_function;
   assign sel[2] = relay_function;

   // ==========================================================
   // comparators
   dsf_cmp u_cmp_v (
      .clk(clk),
      .rst_n(rst_n),
      .level(v_input_level),
      .threshold(start_frequency_setting),
      .below(v_below)
   );

   dsf_cmp u_cmp_i (
      .clk(clk),
      .rst_n(rst_n),
      .level(i_input_level),
      .threshold(DSF_I_4MA_LVL),
      .below(i_below)
   );

   dsf_cmp u_cmp_pv (
      .clk(clk),
      .rst_n(rst_n),
      .level(process_value),
      .threshold(pv_low_limit),
      .below(pv_below_low)
   );

   // ==========================================================
   // helpers
   // strict upper-limit test; a level equal to the limit is not above
   function automatic logic dsf_above(
      input logic [DSF_LVL_W-1:0] level,
      input logic [DSF_LVL_W-1:0] limit
   );
      return level > limit;
   endfunction

   // loss source: current input when selected, voltage otherwise
   function automatic logic dsf_loss_pick(
      input logic use_i,
      input logic i_low,
      input logic v_low
   );
      logic pick;
      pick = v_low;
      if (use_i) begin
         pick = i_low;
      end
      return pick;
   endfunction

   // deceleration request only while loss stands and stop is enabled
   function automatic logic dsf_decel_next(
      input logic loss,
      input logic stop_en
   );
      return loss & stop_en;
   endfunction

   // run state seen by the stage logic on the next cycle
   function automatic dsf_run_t dsf_run_next(
      input logic run_cmd
   );
      dsf_run_t nxt;
      nxt = DSF_STOPPED;
      if (run_cmd) begin
         nxt = DSF_RUNNING;
      end
      return nxt;
   endfunction

   // stage request: set low in run, clear high or on stop, hold only while running
   function automatic logic dsf_stage_next(
      input dsf_run_t run_q,
      input logic run_cmd,
      input logic above_hi,
      input logic below_lo,
      input logic stage_q
   );
      logic nxt;
      nxt = stage_q;
      unique case (run_q)
         DSF_STOPPED: begin
            // clear wins here too, so crossed limits never set it
            nxt = 1'b0;
            if (run_cmd && below_lo && !above_hi) begin
               nxt = 1'b1;
            end
         end
         DSF_RUNNING: begin
            if (!run_cmd) begin
               nxt = 1'b0;
            end else if (above_hi) begin
               nxt = 1'b0;
            end else if (below_lo) begin
               nxt = 1'b1;
            end else begin
               nxt = stage_q;
            end
         end
      endcase
      return nxt;
   endfunction

   // ==========================================================
   // flag logic
   assign pv_above_high = dsf_above(process_value, pv_high_limit);

   always_comb begin
      s_d = s_q;
      s_d.pos_done = positioning_finished;
      // follows input, no latch
      s_d.loss = dsf_loss_pick(use_current_input, i_below,
         v_below);
      s_d.decel = dsf_decel_next(s_d.loss, loss_stop_enable);
      s_d.run = dsf_run_next(forward_run_command);
      s_d.stage2 = dsf_stage_next(s_q.run, forward_run_command,
         pv_above_high, pv_below_low, s_q.stage2);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '{pos_done: DSF_FLAG_RST, loss: DSF_FLAG_RST,
                  stage2: DSF_FLAG_RST, decel: DSF_FLAG_RST,
                  run: dsf_run_t'(DSF_RUN_RST)};
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // terminal routing
   for (genvar g = 0; g < DSF_NOUT; g++) begin : g_route
      dsf_route u_route (
         .clk(clk),
         .rst_n(rst_n),
         .sel(sel[g]),
         .pos_flag(s_q.pos_done),
         .loss_flag(s_q.loss),
         .stage_flag(s_q.stage2),
         .term(output_terminals[g])
      );
   end

   assign positioning_done_flag = s_q.pos_done;
   assign analog_loss_flag = s_q.loss;
   assign second_stage_request = s_q.stage2;
   assign loss_decel_request = s_q.decel;
endmodule // dsf_top

// ==== tb/dsf_relay_model.sv ====
// dsf_relay_model: relay coil driven by one output terminal
// assumes the terminal is a registered level on clk
`timescale 1ns/1ns
module dsf_relay_model (
   input wire logic clk,
   input wire logic term,
   output logic coil
);
   // ==========================================================
   // coil follows the terminal one edge later
   always_ff @(posedge clk) begin
      coil <= term;
   end
endmodule // dsf_relay_model

// ==== tb/dsf_top_sva.sv ====
// dsf_top_sva: assertions on the status flag ports
// assumes clk and the synchronous active-low rst_n of dsf_top
`timescale 1ns/1ns
module dsf_top_sva
   import dsf_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic positioning_finished,
   input wire logic use_current_input,
   input wire logic [DSF_LVL_W-1:0] v_input_level,
   input wire logic [DSF_LVL_W-1:0] i_input_level,
   input wire logic [DSF_LVL_W-1:0] start_frequency_setting,
   input wire logic loss_stop_enable,
   input wire logic forward_run_command,
   input wire logic [DSF_LVL_W-1:0] process_value,
   input wire logic [DSF_LVL_W-1:0] pv_low_limit,
   input wire logic [DSF_LVL_W-1:0] pv_high_limit,
   input wire logic [DSF_SEL_W-1:0] oc1_function,
   input wire logic [DSF_SEL_W-1:0] relay_function,
   input wire logic positioning_done_flag,
   input wire logic analog_loss_flag,
   input wire logic second_stage_request,
   input wire logic loss_decel_request,
   input wire logic [DSF_NOUT-1:0] output_terminals
);
   // ==========================================================
   // properties
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_run_low;
      forward_run_command && process_value < pv_low_limit &&
         process_value <= pv_high_limit;
   endsequence
   property p_pos; $past(rst_n) |->
      positioning_done_flag == $past(positioning_finished); endproperty
   a_pos: assert property (p_pos) else $error("pos flag");
   property p_v_on; (!use_current_input &&
      v_input_level < start_frequency_setting)[*2] |=> analog_loss_flag;
   endproperty
   a_v_on: assert property (p_v_on) else $error("loss on");
   property p_v_off; (!use_current_input &&
      v_input_level >= start_frequency_setting)[*2] |=> !analog_loss_flag;
   endproperty
   a_v_off: assert property (p_v_off) else $error("loss off");
   property p_i_on; (use_current_input &&
      i_input_level < DSF_I_4MA_LVL)[*2] |=> analog_loss_flag; endproperty
   a_i_on: assert property (p_i_on) else $error("i loss");
   property p_set; s_run_low[*2] |=> second_stage_request; endproperty
   a_set: assert property (p_set) else $error("stage set");
   property p_hi; process_value > pv_high_limit |=>
      !second_stage_request; endproperty
   a_hi: assert property (p_hi) else $error("stage high");
   property p_stop; !forward_run_command |=> !second_stage_request;
   endproperty
   a_stop: assert property (p_stop) else $error("stage stop");
   property p_oc1; oc1_function == DSF_FN_POS_DONE |=>
      output_terminals[0] == $past(positioning_done_flag); endproperty
   a_oc1: assert property (p_oc1) else $error("oc1 route");
   property p_rly; relay_function == DSF_FN_STAGE2 |=>
      output_terminals[2] == $past(second_stage_request); endproperty
   a_rly: assert property (p_rly) else $error("relay route");
   property p_decel; loss_decel_request ==
      (analog_loss_flag && $past(loss_stop_enable)); endproperty
   a_decel: assert property (p_decel) else $error("decel");
endmodule // dsf_top_sva
bind dsf_top dsf_top_sva i_sva (.*);

// ==== tb/test_drive_status_output_flags.sv ====
// test_drive_status_output_flags: directed checks of the status flags
// assumes dsf_top with a relay model on the relay terminal
`timescale 1ns/1ns
module test_drive_status_output_flags;
   import dsf_pkg::*;
   logic clk = 0, rst_n = 0, pf = 0, uci = 0, lse = 1, run = 0, coil;
   logic [11:0] v = 12'h800, i = 12'h800, sfs = 12'h100;
   logic [11:0] pv = 12'h050, lo = 12'h100, hi = 12'h300;
   logic [5:0] f1 = 6'h00, f2 = 6'h00, fr = DSF_FN_STAGE2;
   logic pdf, alf, ssr, ldr;
   logic [2:0] ot;
   int n_fail = 0, checked = 0;
   initial forever #4 clk = ~clk;
   dsf_top i_dut (.clk(clk), .rst_n(rst_n), .positioning_finished(pf),
      .use_current_input(uci), .v_input_level(v), .i_input_level(i),
      .start_frequency_setting(sfs), .loss_stop_enable(lse),
      .forward_run_command(run), .process_value(pv), .pv_low_limit(lo),
      .pv_high_limit(hi), .oc1_function(f1), .oc2_function(f2),
      .relay_function(fr), .positioning_done_flag(pdf),
      .analog_loss_flag(alf), .second_stage_request(ssr),
      .loss_decel_request(ldr), .output_terminals(ot));
   dsf_relay_model i_relay (.clk(clk), .term(ot[2]), .coil(coil));
   // ==========================================================
   // tasks
   task w(int n);
      repeat (n) @(negedge clk);
   endtask
   task chk(string s, logic e, logic g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s exp %b got %b", s, e, g);
      end
   endtask
   task results;
      if (n_fail == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ==========================================================
   // sequence
   initial begin
      w(20);
      chk("pos", 1'b0, pdf);
      rst_n = 1;
      f1 = DSF_FN_POS_DONE;
      pf = 1;
      w(4);
      chk("pos", 1'b1, pdf);
      chk("oc1", 1'b1, ot[0]);
      f1 = 6'h16;
      f2 = DSF_FN_ANA_LOSS;
      v = 12'h0ff;
      w(4);
      chk("oc1", 1'b0, ot[0]);
      chk("loss", 1'b1, alf);
      chk("oc2", 1'b1, ot[1]);
      chk("decel", 1'b1, ldr);
      lse = 0;
      w(4);
      chk("decel", 1'b0, ldr);
      v = 12'h100;
      w(4);
      chk("loss", 1'b0, alf);
      uci = 1;
      i = 12'h332;
      w(4);
      chk("loss", 1'b1, alf);
      i = DSF_I_4MA_LVL;
      w(4);
      chk("loss", 1'b0, alf);
      chk("stage", 1'b0, ssr);
      run = 1;
      w(4);
      chk("stage", 1'b1, ssr);
      chk("coil", 1'b1, coil);
      pv = 12'h200;
      w(4);
      chk("stage", 1'b1, ssr);
      pv = 12'h301;
      w(4);
      chk("stage", 1'b0, ssr);
      pv = 12'h200;
      w(4);
      chk("stage", 1'b0, ssr);
      pv = 12'h0ff;
      w(4);
      chk("stage", 1'b1, ssr);
      run = 0;
      w(4);
      chk("stage", 1'b0, ssr);
      lo = 12'h400;
      pv = 12'h350;
      w(2);
      run = 1;
      w(4);
      chk("stage", 1'b0, ssr);
      lo = 12'h100;
      pv = 12'h0ff;
      w(4);
      chk("stage", 1'b1, ssr);
      rst_n = 0;
      w(2);
      chk("pos", 1'b0, pdf);
      chk("stage", 1'b0, ssr);
      chk("relay", 1'b0, ot[2]);
      rst_n = 1;
      w(4);
      chk("pos", 1'b1, pdf);
      chk("stage", 1'b1, ssr);
      run = 0;
      w(4);
      chk("stage", 1'b0, ssr);
      results;
   end
endmodule // test_drive_status_output_flags
